// file: rtl/ltg_cfg.svh
`ifndef LTG_CFG_SVH
`define LTG_CFG_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define LTG_A_LT_LOAD    32'hffff_0300
`define LTG_A_LT_CLO     32'hffff_0304
`define LTG_A_LT_CHI     32'hffff_0308
`define LTG_A_LT_CTRL    32'hffff_030c
`define LTG_A_LT_CLR     32'hffff_0310
`define LTG_A_LT_CAP     32'hffff_0314
`define LTG_A_GT_LOAD    32'hffff_0320
`define LTG_A_GT_CNT     32'hffff_0324
`define LTG_A_GT_CTRL    32'hffff_0328
`define LTG_A_GT_CLR     32'hffff_032c
`define LTG_A_GT_CAP     32'hffff_0330

// ----------------------------------------------------------------
// Writable bits and reset values
// ----------------------------------------------------------------
`define LTG_LT_CTRL_MASK 32'h0003_f7df
`define LTG_GT_CTRL_MASK 32'hff87_ffff
`define LTG_GT_CTRL_RST  32'h0100_0000
`define LTG_GT_CNT_RST   32'hffff_ffff

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define LTG_F_PRE        3:0
`define LTG_B_WIDE       4
`define LTG_F_FMT        5:4
`define LTG_B_PER        6
`define LTG_B_EN         7
`define LTG_B_UP         8
`define LTG_F_LT_CLK     10:9
`define LTG_F_GT_CLK     11:9
`define LTG_F_SEL        16:12
`define LTG_B_CAP        17
`define LTG_B_ISRC       18
`define LTG_B_FLAG       19
`define LTG_B_PEN        23
`define LTG_F_POST       31:24

// ----------------------------------------------------------------
// Clock sources, prescaler, postscaler, time of day
// ----------------------------------------------------------------
`define LTG_LT_CLK_CORE  2'h0
`define LTG_LT_CLK_LP    2'h1
`define LTG_LT_CLK_XTAL  2'h2
`define LTG_GT_CLK_CORE  3'h0
`define LTG_GT_CLK_LP    3'h1
`define LTG_GT_CLK_G8    3'h2
`define LTG_GT_CLK_LAST  3'h3
`define LTG_PRE_16       4'h4
`define LTG_PRE_256      4'h8
`define LTG_PRE_32K      4'hf
`define LTG_TERM_16      15'h000f
`define LTG_TERM_256     15'h00ff
`define LTG_TERM_32K     15'h7fff
`define LTG_POST_MIN     8'h01
`define LTG_TOD_CS_MAX   8'h63
`define LTG_TOD_MS_MAX   8'h3b
`define LTG_TOD_H23      8'h17
`define LTG_TOD_H255     8'hff

`endif

// file: rtl/ltg_pkg.sv
package ltg_pkg;

  typedef enum logic [1:0] {
    ltg_fmt_bin  = 2'h0,
    ltg_fmt_rsv  = 2'h1,
    ltg_fmt_h23  = 2'h2,
    ltg_fmt_h255 = 2'h3
  } ltg_fmt_e;

  typedef struct packed {
    logic [17:0] ctrl;
    logic [15:0] load;
    logic        tgl;
  } ltg_lt_sync_s;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] load;
    logic        tgl;
  } ltg_gt_sync_s;

endpackage

// file: rtl/ltg_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ltg_tick_if;
  logic src_tick;
  logic pre_tick;
  modport src (output src_tick, output pre_tick);
  modport snk (input src_tick, input pre_tick);
endinterface

`default_nettype wire

// file: rtl/ltg_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two stages, both advanced by the timer tick, so a word written on the
// core side needs two timer periods before the counter logic sees it.
module ltg_sync #(
  parameter int W = 32
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s1_q <= '0;
      q    <= '0;
    end
    else if (tick)
    begin
      s1_q <= d;
      q    <= s1_q;
    end
  end
endmodule

`default_nettype wire

// file: rtl/ltg_prescale.sv
`timescale 1ns/1ps
`default_nettype none
`include "ltg_cfg.svh"

module ltg_prescale #(
  parameter int DIV_W = 15
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       src_level,
  input  wire logic       src_is_core,
  input  wire logic       src_on,
  input  wire logic [3:0] code,
  ltg_tick_if.src         tk
);
  logic             lvl_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_d;
  logic [DIV_W-1:0] term;
  logic             wrap;

  function automatic logic [DIV_W-1:0] div_term(input logic [3:0] c);
    case (c)
      `LTG_PRE_16:  div_term = DIV_W'(`LTG_TERM_16);
      `LTG_PRE_256: div_term = DIV_W'(`LTG_TERM_256);
      `LTG_PRE_32K: div_term = DIV_W'(`LTG_TERM_32K);
      default:      div_term = '0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Source tick and divider
  // ----------------------------------------------------------------
  assign tk.src_tick = src_on & (src_is_core | (src_level & ~lvl_q));
  assign term        = div_term(code);
  // A compare rather than an equality keeps the divider safe when the code shrinks mid-count.
  assign wrap        = div_q >= term;
  assign tk.pre_tick = tk.src_tick & wrap;
  assign div_d       = !tk.src_tick ? div_q : wrap ? '0 : div_q + DIV_W'(1);

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lvl_q <= 1'b0;
      div_q <= '0;
    end
    else
    begin
      lvl_q <= src_level;
      div_q <= div_d;
    end
  end
endmodule

`default_nettype wire

// file: rtl/ltg_timers.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ltg_cfg.svh"

// Behaviour
// - Control and data reach timer logic through two timer-clocked stages.
// - Counter acts on a register write only after two timer periods.
// - Wide lifetime mode counts up from zero; count read as low and high.
// - Narrow lifetime mode counts up or down from the 16-bit load value.
// - Each new assertion of the selected event copies count to capture, no stop.
// - Capture enable is bit 17; bits 16 to 12 pick the event source.
// - Lifetime reloads from load (zero in wide mode) on overflow in periodic mode and when clear is written.
// - Writing lifetime clear clears its interrupt, only in narrow mode.
// - Lifetime bits 10 to 9 select core, low power, crystal or precision clock.
// - Prescaler bits 3 to 0 divide by 1, 16, 256 or 32768.
// - Bit 7 enables the counter; bit 6 picks periodic over free running.
// - Lifetime bit 4 picks 48-bit over 16-bit operation.
// - Bit 8 counts up when set; lifetime honours it only in narrow mode.
// - Lifetime load register takes a single write.
// - General timer counts 32 bits up or down from four selectable sources.
// - General count is binary or hours, minutes, seconds, hundredths.
// - Postscaler counts 1 to 255 timeouts, bit 23 enables, bit 18 routes.
// - General timer keeps counting in low power on pin or low power source.
// - General timer reloads from its load on overflow in periodic mode and on clear write.
// - General clear write clears its interrupt; capture leaves counter running.
// - Interrupt when count reaches zero counting down or full scale up.
// - Periodic mode reloads from load at the interrupt condition; wide lifetime reloads zero.
// - Free-running mode wraps instead of reloading.
module ltg_timers (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic        lp_osc,
  input  wire logic        xtal_osc,
  input  wire logic        prec_osc,
  input  wire logic        gpio_8_in,
  input  wire logic        gpio_5_in,
  input  wire logic        low_power,
  input  wire logic [31:0] irq_sources,
  output logic      [31:0] rd_data,
  output logic             lifetime_irq,
  output logic             general_irq
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [17:0] lt_ctrl_q, lt_ctrl_d;
  logic [15:0] lt_load_q, lt_load_d;
  logic        lt_done_q;
  logic        lt_tgl_q;
  logic        lt_seen_q;
  logic [15:0] lt_cap_q, lt_cap_d;
  logic [47:0] lt_cnt_q, lt_cnt_d;
  logic [31:0] gt_ctrl_q, gt_ctrl_d;
  logic [31:0] gt_load_q;
  logic        gt_tgl_q;
  logic        gt_seen_q;
  logic [31:0] gt_cap_q, gt_cap_d;
  logic [31:0] gt_cnt_q, gt_cnt_d;
  logic [7:0]  gt_post_q, gt_post_d;
  logic        gt_flag_q;
  logic [31:0] src_prev_q;

  ltg_pkg::ltg_lt_sync_s lt_s;
  ltg_pkg::ltg_gt_sync_s gt_s;
  ltg_pkg::ltg_fmt_e     gt_fmt;

  logic        wr_lt_load, wr_lt_ctrl, wr_lt_clr, wr_lt_cap;
  logic        wr_gt_load, wr_gt_ctrl, wr_gt_clr;
  logic [31:0] ev;
  logic [31:0] rd_mux;
  logic [1:0]  lt_src;
  logic        lt_lvl;
  logic [2:0]  gt_src;
  logic        gt_lvl;
  logic        gt_core;
  logic        lt_wide, lt_up, lt_hit, lt_reload, lt_step, lt_cap_ev, lt_irq_d;
  logic [47:0] lt_init, lt_inc;
  logic        gt_up, gt_tod, gt_hit, gt_reload, gt_step, gt_tmo, gt_cap_ev, gt_irq_d;
  logic        gt_pen, gt_post_hit;
  logic [7:0]  gt_hmax, gt_tgt;
  logic [31:0] gt_full, gt_inc;

  ltg_tick_if lt_tk ();
  ltg_tick_if gt_tk ();

  // Step one time-of-day digit pair after another, carrying or borrowing upward.
  function automatic logic [31:0] tod_step(input logic [31:0] v, input logic up, input logic [7:0] hmax);
    logic [31:0] r;
    logic [7:0]  lim;
    logic [7:0]  f;
    logic        c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      lim = (i == 3) ? hmax : (i == 0) ? `LTG_TOD_CS_MAX : `LTG_TOD_MS_MAX;
      f   = r[8*i +: 8];
      if (c)
      begin
        if (up)
        begin
          c = (f == lim);
          f = c ? 8'h00 : f + 8'h01;
        end
        else
        begin
          c = (f == 8'h00);
          f = c ? lim : f - 8'h01;
        end
      end
      r[8*i +: 8] = f;
    end
    tod_step = r;
  endfunction

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  assign wr_lt_load = wr_en & (addr == `LTG_A_LT_LOAD);
  assign wr_lt_ctrl = wr_en & (addr == `LTG_A_LT_CTRL);
  assign wr_lt_clr  = wr_en & (addr == `LTG_A_LT_CLR);
  assign wr_lt_cap  = wr_en & (addr == `LTG_A_LT_CAP);
  assign wr_gt_load = wr_en & (addr == `LTG_A_GT_LOAD);
  assign wr_gt_ctrl = wr_en & (addr == `LTG_A_GT_CTRL);
  assign wr_gt_clr  = wr_en & (addr == `LTG_A_GT_CLR);

  assign lt_ctrl_d = wr_lt_ctrl ? wr_data[17:0] & 18'(`LTG_LT_CTRL_MASK) : lt_ctrl_q;
  assign lt_load_d = (wr_lt_load & ~lt_done_q) ? wr_data[15:0] : lt_load_q;
  assign gt_ctrl_d = wr_gt_ctrl ? wr_data & `LTG_GT_CTRL_MASK : gt_ctrl_q;

  // Load and write-only registers read as zero.
  // With the postscaler off its field reads back the target, so the reset value shows a target of one.
  assign rd_mux =
    (addr == `LTG_A_LT_CLO)  ? {16'h0000, lt_cnt_q[15:0]} :
    (addr == `LTG_A_LT_CHI)  ? lt_cnt_q[47:16] :
    (addr == `LTG_A_LT_CTRL) ? {14'h0000, lt_ctrl_q} :
    (addr == `LTG_A_LT_CAP)  ? {16'h0000, lt_cap_q} :
    (addr == `LTG_A_GT_CNT)  ? gt_cnt_q :
    (addr == `LTG_A_GT_CTRL) ? {gt_ctrl_q[`LTG_B_PEN] ? gt_post_q : gt_ctrl_q[`LTG_F_POST],
                                gt_ctrl_q[23:20], gt_flag_q, gt_ctrl_q[18:0]} :
    (addr == `LTG_A_GT_CAP)  ? gt_cap_q : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Clock sources and crossing into the timer side
  // ----------------------------------------------------------------
  // The source select itself clocks the crossing, so it is taken from the core side.
  assign lt_src  = lt_ctrl_q[`LTG_F_LT_CLK];
  assign lt_lvl  = (lt_src == `LTG_LT_CLK_LP) ? lp_osc : (lt_src == `LTG_LT_CLK_XTAL) ? xtal_osc : prec_osc;
  assign gt_src  = gt_ctrl_q[`LTG_F_GT_CLK];
  assign gt_core = gt_src == `LTG_GT_CLK_CORE;
  assign gt_lvl  = (gt_src == `LTG_GT_CLK_LP) ? lp_osc : (gt_src == `LTG_GT_CLK_G8) ? gpio_8_in : gpio_5_in;

  ltg_prescale #(
    .DIV_W(15)
  ) u_lt_pre (
    .core_clk    (core_clk),
    .rst         (rst),
    .src_level   (lt_lvl),
    .src_is_core (lt_src == `LTG_LT_CLK_CORE),
    .src_on      (1'b1),
    .code        (lt_s.ctrl[`LTG_F_PRE]),
    .tk          (lt_tk.src)
  );

  // A stopped core clock halts a core-clocked timer; pin and oscillator sources keep running.
  ltg_prescale #(
    .DIV_W(15)
  ) u_gt_pre (
    .core_clk    (core_clk),
    .rst         (rst),
    .src_level   (gt_lvl),
    .src_is_core (gt_core),
    .src_on      ((gt_src <= `LTG_GT_CLK_LAST) & ~(low_power & gt_core)),
    .code        (gt_s.ctrl[`LTG_F_PRE]),
    .tk          (gt_tk.src)
  );

  ltg_sync #(
    .W($bits(ltg_pkg::ltg_lt_sync_s))
  ) u_lt_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (lt_tk.src_tick),
    .d        ({lt_ctrl_q, lt_load_q, lt_tgl_q}),
    .q        (lt_s)
  );

  ltg_sync #(
    .W($bits(ltg_pkg::ltg_gt_sync_s))
  ) u_gt_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (gt_tk.src_tick),
    .d        ({gt_ctrl_q, gt_load_q, gt_tgl_q}),
    .q        (gt_s)
  );

  // ----------------------------------------------------------------
  // Lifetime counter
  // ----------------------------------------------------------------
  assign lt_wide   = lt_s.ctrl[`LTG_B_WIDE];
  assign lt_up     = lt_wide | lt_s.ctrl[`LTG_B_UP];
  assign lt_hit    = lt_wide ? &lt_cnt_q : lt_up ? &lt_cnt_q[15:0] : ~|lt_cnt_q[15:0];
  assign lt_init   = lt_wide ? 48'h0 : {32'h0000_0000, lt_s.load};
  assign lt_reload = lt_s.tgl ^ lt_seen_q;
  assign lt_step   = lt_s.ctrl[`LTG_B_EN] & lt_tk.pre_tick;
  assign lt_inc    = lt_wide ? lt_cnt_q + 48'h1 :
                     {32'h0000_0000, lt_up ? lt_cnt_q[15:0] + 16'h0001 : lt_cnt_q[15:0] - 16'h0001};
  assign lt_cnt_d  = lt_reload ? lt_init :
                     !lt_step ? lt_cnt_q :
                     (lt_hit & lt_s.ctrl[`LTG_B_PER]) ? lt_init : lt_inc;
  // A timeout in the same cycle as the clear write keeps the interrupt set.
  assign lt_irq_d  = (lt_step & lt_hit) | (lifetime_irq & ~(wr_lt_clr & ~lt_ctrl_q[`LTG_B_WIDE]));

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------
  assign ev        = irq_sources & ~src_prev_q;
  assign lt_cap_ev = lt_s.ctrl[`LTG_B_CAP] & ev[lt_s.ctrl[`LTG_F_SEL]];
  assign gt_cap_ev = gt_s.ctrl[`LTG_B_CAP] & ev[gt_s.ctrl[`LTG_F_SEL]];
  assign lt_cap_d  = lt_cap_ev ? lt_cnt_q[15:0] : wr_lt_cap ? wr_data[15:0] : lt_cap_q;
  assign gt_cap_d  = gt_cap_ev ? gt_cnt_q : gt_cap_q;

  // ----------------------------------------------------------------
  // General counter
  // ----------------------------------------------------------------
  assign gt_fmt    = ltg_pkg::ltg_fmt_e'(gt_s.ctrl[`LTG_F_FMT]);
  assign gt_tod    = (gt_fmt == ltg_pkg::ltg_fmt_h23) | (gt_fmt == ltg_pkg::ltg_fmt_h255);
  assign gt_hmax   = (gt_fmt == ltg_pkg::ltg_fmt_h23) ? `LTG_TOD_H23 : `LTG_TOD_H255;
  assign gt_full   = gt_tod ? {gt_hmax, `LTG_TOD_MS_MAX, `LTG_TOD_MS_MAX, `LTG_TOD_CS_MAX} : 32'hffff_ffff;
  assign gt_up     = gt_s.ctrl[`LTG_B_UP];
  assign gt_hit    = gt_up ? (gt_cnt_q == gt_full) : (gt_cnt_q == 32'h0000_0000);
  assign gt_inc    = gt_tod ? tod_step(gt_cnt_q, gt_up, gt_hmax) :
                     gt_up ? gt_cnt_q + 32'h0000_0001 : gt_cnt_q - 32'h0000_0001;
  assign gt_reload = gt_s.tgl ^ gt_seen_q;
  assign gt_step   = gt_s.ctrl[`LTG_B_EN] & gt_tk.pre_tick;
  assign gt_tmo    = gt_step & gt_hit;
  assign gt_cnt_d  = gt_reload ? gt_s.load :
                     !gt_step ? gt_cnt_q :
                     (gt_hit & gt_s.ctrl[`LTG_B_PER]) ? gt_s.load : gt_inc;

  // ----------------------------------------------------------------
  // Postscaler
  // ----------------------------------------------------------------
  // A target of zero behaves as one, so the range is one to 255 timeouts.
  assign gt_pen      = gt_s.ctrl[`LTG_B_PEN];
  assign gt_tgt      = (gt_s.ctrl[`LTG_F_POST] == 8'h00) ? `LTG_POST_MIN : gt_s.ctrl[`LTG_F_POST];
  assign gt_post_hit = gt_tmo & gt_pen & ((gt_post_q + 8'h01) == gt_tgt);
  assign gt_post_d   = (gt_reload | ~gt_pen | gt_post_hit) ? 8'h00 : gt_tmo ? gt_post_q + 8'h01 : gt_post_q;
  assign gt_irq_d    = (gt_s.ctrl[`LTG_B_ISRC] ? gt_post_hit : gt_tmo) | (general_irq & ~wr_gt_clr);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lt_ctrl_q    <= '0;
      lt_load_q    <= '0;
      lt_done_q    <= 1'b0;
      lt_tgl_q     <= 1'b0;
      lt_cap_q     <= '0;
      gt_ctrl_q    <= `LTG_GT_CTRL_RST;
      gt_load_q    <= '0;
      gt_tgl_q     <= 1'b0;
      src_prev_q   <= '0;
      rd_data      <= '0;
    end
    else
    begin
      lt_ctrl_q    <= lt_ctrl_d;
      lt_load_q    <= lt_load_d;
      lt_done_q    <= lt_done_q | wr_lt_load;
      lt_tgl_q     <= lt_tgl_q ^ wr_lt_clr;
      lt_cap_q     <= lt_cap_d;
      gt_ctrl_q    <= gt_ctrl_d;
      gt_load_q    <= wr_gt_load ? wr_data : gt_load_q;
      gt_tgl_q     <= gt_tgl_q ^ wr_gt_clr;
      src_prev_q   <= irq_sources;
      rd_data      <= rd_en ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lt_seen_q    <= 1'b0;
      lt_cnt_q     <= '0;
      lifetime_irq <= 1'b0;
      gt_seen_q    <= 1'b0;
      gt_cnt_q     <= `LTG_GT_CNT_RST;
      gt_cap_q     <= '0;
      gt_post_q    <= '0;
      gt_flag_q    <= 1'b0;
      general_irq  <= 1'b0;
    end
    else
    begin
      lt_seen_q    <= lt_s.tgl;
      lt_cnt_q     <= lt_cnt_d;
      lifetime_irq <= lt_irq_d;
      gt_seen_q    <= gt_s.tgl;
      gt_cnt_q     <= gt_cnt_d;
      gt_cap_q     <= gt_cap_d;
      gt_post_q    <= gt_post_d;
      gt_flag_q    <= gt_post_hit | (gt_flag_q & ~wr_gt_clr);
      general_irq  <= gt_irq_d;
    end
  end
endmodule

`default_nettype wire

// file: tb/ltg_timers_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "ltg_cfg.svh"

module ltg_timers_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rd_data,
  input wire logic        lifetime_irq,
  input wire logic        general_irq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_ltw;
    wr_en && addr == `LTG_A_LT_CTRL;
  endsequence
  sequence s_ltr;
    rd_en && addr == `LTG_A_LT_CTRL;
  endsequence
  sequence s_gtw;
    wr_en && addr == `LTG_A_GT_CTRL;
  endsequence
  sequence s_gtr;
    rd_en && addr == `LTG_A_GT_CTRL;
  endsequence

  property p_idle_zero;
    !rd_en |=> rd_data == 32'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data not zero outside a read");
  property p_load_wo;
    rd_en && addr == `LTG_A_LT_LOAD |=> rd_data == 32'h0;
  endproperty
  a_load_wo: assert property (p_load_wo)
    else $error("lifetime load readable");
  property p_gload_wo;
    rd_en && addr == `LTG_A_GT_LOAD |=> rd_data == 32'h0;
  endproperty
  a_gload_wo: assert property (p_gload_wo)
    else $error("general load readable");
  property p_clo_width;
    rd_en && addr == `LTG_A_LT_CLO |=> rd_data[31:16] == 16'h0;
  endproperty
  a_clo_width: assert property (p_clo_width)
    else $error("low count wider than 16 bits");
  property p_cap_width;
    rd_en && addr == `LTG_A_LT_CAP |=> rd_data[31:16] == 16'h0;
  endproperty
  a_cap_width: assert property (p_cap_width)
    else $error("capture wider than 16 bits");
  property p_ltirq_hold;
    lifetime_irq && !(wr_en && addr == `LTG_A_LT_CLR) |=> lifetime_irq;
  endproperty
  a_ltirq_hold: assert property (p_ltirq_hold)
    else $error("lifetime irq dropped without clear");
  property p_gtirq_hold;
    general_irq && !(wr_en && addr == `LTG_A_GT_CLR) |=> general_irq;
  endproperty
  a_gtirq_hold: assert property (p_gtirq_hold)
    else $error("general irq dropped without clear");
  property p_ltctrl_rb;
    s_ltw ##1 !wr_en ##1 s_ltr |=> rd_data == ($past(wr_data, 3) & `LTG_LT_CTRL_MASK);
  endproperty
  a_ltctrl_rb: assert property (p_ltctrl_rb)
    else $error("lifetime control readback wrong");
  property p_gtctrl_rb;
    s_gtw ##1 !wr_en ##1 s_gtr |=> (rd_data & 32'h0087_ffff) == ($past(wr_data, 3) & 32'h0087_ffff);
  endproperty
  a_gtctrl_rb: assert property (p_gtctrl_rb)
    else $error("general control readback wrong");
endmodule

bind ltg_timers ltg_timers_monitor u_mon (
  .core_clk    (core_clk),
  .rst         (rst),
  .addr        (addr),
  .wr_data     (wr_data),
  .wr_en       (wr_en),
  .rd_en       (rd_en),
  .rd_data     (rd_data),
  .lifetime_irq(lifetime_irq),
  .general_irq (general_irq)
);

`default_nettype wire

// file: tb/ltg_timers_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ltg_cfg.svh"

module ltg_timers_tb;
  typedef struct packed {
    logic        we;
    logic [31:0] a;
    logic [31:0] wd;
    logic [31:0] exp;
  } ltg_row_s;

  localparam ltg_row_s ROWS [10] = '{
    '{1'b0, `LTG_A_LT_LOAD, 32'h0, 32'h0},
    '{1'b0, `LTG_A_LT_CLO, 32'h0, 32'h0},
    '{1'b0, `LTG_A_LT_CHI, 32'h0, 32'h0},
    '{1'b0, `LTG_A_LT_CTRL, 32'h0, 32'h0},
    '{1'b0, `LTG_A_LT_CAP, 32'h0, 32'h0},
    '{1'b0, `LTG_A_GT_CNT, 32'h0, 32'hffff_ffff},
    '{1'b0, 32'hffff_0318, 32'h0, 32'h0},
    '{1'b1, `LTG_A_LT_CTRL, 32'hffff_ffff, 32'h0003_f7df},
    '{1'b1, `LTG_A_LT_CTRL, 32'h0, 32'h0},
    '{1'b1, `LTG_A_LT_CHI, 32'h55, 32'h0}
  };

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [31:0] wr_data = 32'h0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        lp_osc = 1'b0;
  logic [2:0]  lp_div = 3'h0;
  logic        low_power = 1'b0;
  logic [31:0] irq_sources = 32'h0;
  logic [31:0] rd_data;
  logic        lifetime_irq;
  logic        general_irq;
  logic [31:0] v;
  logic [31:0] w;
  int          n_fail = 0;
  int          cmp_count = 0;

  always #2 core_clk = ~core_clk;

  // A slow source tick, so the general timer has something to count in low power.
  always @(posedge core_clk)
  begin
    lp_div <= lp_div + 3'h1;
    lp_osc <= lp_div[2];
  end

  ltg_timers dut (
    .core_clk    (core_clk),
    .rst         (rst),
    .addr        (addr),
    .wr_data     (wr_data),
    .wr_en       (wr_en),
    .rd_en       (rd_en),
    .lp_osc      (lp_osc),
    .xtal_osc    (1'b0),
    .prec_osc    (1'b0),
    .gpio_8_in   (1'b0),
    .gpio_5_in   (1'b0),
    .low_power   (low_power),
    .irq_sources (irq_sources),
    .rd_data     (rd_data),
    .lifetime_irq(lifetime_irq),
    .general_irq (general_irq)
  );

  task automatic summarize();
    $display("TB: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic pulse(input int b);
    @(posedge core_clk);
    irq_sources[b] <= 1'b1;
    @(posedge core_clk);
    irq_sources[b] <= 1'b0;
  endtask

  // Waits for an irq level; running out of cycles ends the run.
  task automatic wait_flag(input int which, input logic lvl, input int bound);
    logic f;
    for (int i = 0; i < bound; i++)
    begin
      @(posedge core_clk);
      #1;
      f = (which == 0) ? lifetime_irq : general_irq;
      if (f === lvl)
        return;
    end
    chk1(f, lvl);
    summarize();
  endtask

  initial
  begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    for (int k = 0; k < 10; k++)
    begin
      if (ROWS[k].we)
        wr(ROWS[k].a, ROWS[k].wd);
      rd(ROWS[k].a, v);
      chk32(v, ROWS[k].exp);
    end
    $display("TB: register table done");
    wr(`LTG_A_LT_LOAD, 32'h5);
    wr(`LTG_A_LT_LOAD, 32'h9);
    wr(`LTG_A_LT_CTRL, 32'hc4);
    repeat (4) @(posedge core_clk);
    wr(`LTG_A_LT_CLR, 32'h0);
    wait_flag(0, 1'b1, 300);
    rd(`LTG_A_LT_CLO, v);
    chk32(v, 32'h5);
    repeat (6) @(posedge core_clk);
    rd(`LTG_A_LT_CLO, v);
    chk32(v, 32'h5);
    wr(`LTG_A_LT_CLR, 32'h0);
    wait_flag(0, 1'b0, 8);
    $display("TB: lifetime periodic done");
    wr(`LTG_A_LT_CTRL, 32'h0002_3084);
    wr(`LTG_A_LT_CAP, 32'h1234);
    wr(`LTG_A_LT_CLR, 32'h0);
    wait_flag(0, 1'b1, 300);
    rd(`LTG_A_LT_CLO, v);
    chk32(v, 32'hffff);
    pulse(4);
    rd(`LTG_A_LT_CAP, v);
    chk32(v, 32'h1234);
    pulse(3);
    rd(`LTG_A_LT_CAP, v);
    chk32(v, 32'hffff);
    $display("TB: lifetime capture done");
    wr(`LTG_A_LT_CLR, 32'h0);
    wr(`LTG_A_LT_CTRL, 32'h90);
    wr(`LTG_A_LT_CLR, 32'h0);
    repeat (4) @(posedge core_clk);
    rd(`LTG_A_LT_CLO, v);
    rd(`LTG_A_LT_CLO, w);
    chk32(w, v + 32'h2);
    rd(`LTG_A_LT_CHI, w);
    chk32(w, 32'h0);
    wr(`LTG_A_LT_CTRL, 32'h0);
    $display("TB: lifetime wide done");
    wr(`LTG_A_GT_LOAD, 32'h14);
    wr(`LTG_A_GT_CTRL, 32'hc4);
    rd(`LTG_A_GT_CTRL, v);
    chk32(v & 32'h0087_ffff, 32'hc4);
    wr(`LTG_A_GT_CLR, 32'h0);
    wait_flag(1, 1'b1, 600);
    rd(`LTG_A_GT_CNT, v);
    chk32(v, 32'h14);
    @(posedge core_clk);
    low_power <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(`LTG_A_GT_CNT, v);
    repeat (40) @(posedge core_clk);
    rd(`LTG_A_GT_CNT, w);
    chk32(w, v);
    wr(`LTG_A_GT_CTRL, 32'h2c0);
    repeat (24) @(posedge core_clk);
    rd(`LTG_A_GT_CNT, v);
    repeat (40) @(posedge core_clk);
    rd(`LTG_A_GT_CNT, w);
    chk1(w !== v, 1'b1);
    $display("TB: general timer done");
    @(posedge core_clk);
    low_power <= 1'b0;
    wr(`LTG_A_GT_CTRL, 32'h0);
    repeat (4) @(posedge core_clk);
    wr(`LTG_A_GT_CLR, 32'h0);
    wr(`LTG_A_GT_CTRL, 32'h0286_30c0);
    repeat (30) @(posedge core_clk);
    #1;
    chk1(general_irq, 1'b0);
    wait_flag(1, 1'b1, 40);
    rd(`LTG_A_GT_CTRL, v);
    chk32(v, 32'h008e_30c0);
    pulse(3);
    rd(`LTG_A_GT_CAP, v);
    chk32(v, 32'h11);
    wr(`LTG_A_GT_CLR, 32'h0);
    wait_flag(1, 1'b0, 8);
    $display("TB: postscaler and capture done");
    @(posedge core_clk);
    rst <= 1'b1;
    low_power <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk1(general_irq, 1'b0);
    chk1(lifetime_irq, 1'b0);
    rd(`LTG_A_GT_CTRL, v);
    chk32(v, `LTG_GT_CTRL_RST);
    $display("TB: reset done");
    summarize();
  end
endmodule

`default_nettype wire
